// [src/ndt_pkg.sv]
// Constants and field layout for the non-page DRAM timing generator
package ndt_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [15:0] NDT_TIMING_IDX = 16'h4072; // Timing register
  localparam logic [15:0] NDT_STATUS_IDX = 16'h4073; // Sequencer status
  localparam int NDT_ADDR_W = 18; // Byte address width
  // Field positions in the timing register
  localparam int NDT_MODE_LSB = 13; // Row strobe start select, 2 bits
  localparam int NDT_RAW_DIS_BIT = 12; // Read-after-write wait disable
  localparam int NDT_WR_DEL_LSB = 10; // Write column delay, 2 bits
  localparam int NDT_RD_DEL_LSB = 8; // Read column delay, 2 bits
  localparam int NDT_HOLD_LSB = 5; // Row hold after column, 2 bits
  localparam int NDT_CASW_LSB = 2; // Column strobe width, 3 bits
  localparam int NDT_WS_LSB = 0; // Minimum wait states, 2 bits
  localparam logic [15:0] NDT_KEEP_MASK = 16'h7F7F; // Bits 15 and 7 dropped
  localparam logic [15:0] NDT_TIMING_RESET = 16'h0000; // Reset value
  // Row strobe start codes
  localparam logic [1:0] NDT_MODE_FROM_STATUS = 2'h3; // Start mid status
  // Timing in half processor clocks, counted from the status sample
  localparam logic [6:0] NDT_STATUS_MID_H = 7'h01; // Middle of status
  localparam logic [6:0] NDT_TSM_H = 7'h02; // End of status cycle
  localparam logic [6:0] NDT_SAME_BANK_H = 7'h03; // Mid first command cycle
  localparam logic [6:0] NDT_ONE_CLK_H = 7'h02; // One processor clock
  localparam logic [6:0] NDT_RAW_OFF_H = 7'h02; // Tsm+1
  localparam logic [6:0] NDT_EMS_OFF_H = 7'h04; // Tsm+2
  localparam logic [6:0] NDT_BOTH_OFF_H = 7'h08; // Tsm+4
  // Extra wait states per access class
  localparam logic [6:0] NDT_RAW_RD_WS = 7'h01;
  localparam logic [6:0] NDT_EMS_RD_WS = 7'h02;
  localparam logic [6:0] NDT_EMS_WR_WS = 7'h01;
  localparam logic [6:0] NDT_BOTH_RD_WS = 7'h03;
  // Processor clock half period
  localparam int NDT_CLK_PERIOD_NS = 10; // System clock period
  localparam int NDT_HALF_NS = 20; // Default processor half period
  localparam int NDT_HALF_CYCLES = (NDT_HALF_NS + NDT_CLK_PERIOD_NS - 1) / NDT_CLK_PERIOD_NS;
  typedef enum logic [0:0] {NDT_IDLE, NDT_RUN} ndt_state_e;
endpackage : ndt_pkg

// [src/ndt_timing_gen.sv]
// Non-page DRAM cycle timing generator with Wishbone timing register
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module ndt_timing_gen
  import ndt_pkg::*;
#(
  parameter int HALF_CYCLES = NDT_HALF_CYCLES // System clocks per processor half period
) (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic wbCyc, // Wishbone cycle
  input wire logic wbStb, // Wishbone strobe
  input wire logic wbWe, // Wishbone write enable
  input wire logic [NDT_ADDR_W-1:0] wbAdr, // Wishbone byte address
  input wire logic [3:0] wbSel, // Wishbone byte selects
  input wire logic [31:0] wbDatIn, // Wishbone write data
  output logic [31:0] wbDatOut, // Wishbone read data
  output logic wbAck, // Wishbone acknowledge
  input wire logic statusStrobeA_n, // Write status, active low
  input wire logic statusStrobeB_n, // Read status, active low
  input wire logic [1:0] bankSel, // DRAM bank of this access
  input wire logic interleaveOn, // Non-page interleave selected
  input wire logic interleaveMiss, // Interleave wait cycle
  input wire logic expansionAccess, // Expansion memory access
  input wire logic dataLatched, // Processor has latched read data
  input wire logic [15:0] dramDataIn, // Data from DRAM array
  output logic procClock, // Processor clock
  output logic rowStrobe_n, // Row strobe, active low
  output logic colStrobe_n, // Column strobe, active low
  output logic colAddrSel, // High selects column address
  output logic dramWrite_n, // DRAM write enable, active low
  output logic readyOut, // One-cycle end-of-cycle pulse
  output logic [15:0] procDataOut, // Read data to processor
  output logic procDataOe, // Drives processor data bus
  output logic extCacheEnable // External cache allowed
);

  // Whole module state
  typedef struct packed {
    logic [15:0] timing; // Timing register
    logic [31:0] rdData; // Bus read data
    logic ack; // Bus acknowledge
    logic [15:0] divCnt; // Half period divider
    logic pclk; // Processor clock level
    ndt_state_e state; // Sequencer state
    logic [6:0] half; // Half clocks since status sample
    logic isWrite; // Current cycle is a write
    logic rawHit; // Read after write counted
    logic emsHit; // Expansion memory access
    logic ilvHit; // Interleave wait
    logic sameBank; // Back-to-back to same bank
    logic lastWrite; // Previous cycle was a write
    logic lastValid; // A previous cycle exists
    logic [1:0] lastBank; // Bank of previous cycle
    logic rasN; // Row strobe
    logic casN; // Column strobe
    logic colSel; // Column address select
    logic wrN; // DRAM write enable
    logic ready; // Ready pulse
    logic [15:0] pData; // Latched read data
    logic pOe; // Read data drive
  } ndt_state_s;

  ndt_state_s s;
  ndt_state_s next_s;

  // Timing fields read straight from the live register
  logic [1:0] mode;
  logic [6:0] delH;
  logic [1:0] delCode;
  logic [6:0] rasOff;
  logic [6:0] rasStart;
  logic [6:0] casRef;
  logic [6:0] casStart;
  logic [6:0] casEnd;
  logic [6:0] rasEnd;
  logic [6:0] extraWs;
  logic [6:0] minEnd;
  logic [6:0] readyAt;
  logic tick;
  logic regHit;
  logic statHit;

  // Decode of the timing fields; no shadow copy, so a write acts at once
  always_comb begin
    mode = s.timing[NDT_MODE_LSB +: 2];
    delCode = s.isWrite ? s.timing[NDT_WR_DEL_LSB +: 2] : s.timing[NDT_RD_DEL_LSB +: 2];
    delH = NDT_ONE_CLK_H + {5'h00, delCode};
    // Special-cycle row offsets from end of status cycle
    if (s.rawHit && s.ilvHit) begin
      rasOff = NDT_BOTH_OFF_H;
      extraWs = s.isWrite ? 7'h00 : NDT_BOTH_RD_WS;
    end else if (s.emsHit || s.ilvHit) begin
      rasOff = NDT_EMS_OFF_H;
      extraWs = s.isWrite ? NDT_EMS_WR_WS : NDT_EMS_RD_WS;
    end else if (s.rawHit) begin
      rasOff = NDT_RAW_OFF_H;
      extraWs = NDT_RAW_RD_WS;
    end else begin
      rasOff = 7'h00;
      extraWs = 7'h00;
    end
    // Row start point
    if (rasOff != 7'h00) begin
      rasStart = NDT_TSM_H + rasOff;
    end else if (s.sameBank) begin
      rasStart = NDT_SAME_BANK_H;
    end else if (mode == NDT_MODE_FROM_STATUS) begin
      rasStart = NDT_STATUS_MID_H;
    end else begin
      rasStart = NDT_TSM_H;
    end
    // Column delay reference follows the status strobe when row starts there
    casRef = (mode == NDT_MODE_FROM_STATUS && rasStart == NDT_STATUS_MID_H) ? NDT_STATUS_MID_H : rasStart;
    casStart = casRef + delH;
    // Width 1..4.5 clocks, trimmed half a clock for delay codes 01 and 10
    casEnd = casStart + NDT_ONE_CLK_H + {4'h0, s.timing[NDT_CASW_LSB +: 3]}
      - {6'h00, delCode[0] ^ delCode[1]};
    // Hold 1..2.5 clocks, trimmed half a clock on 1.5 or 2.5 delays
    rasEnd = casEnd + NDT_ONE_CLK_H + {5'h00, s.timing[NDT_HOLD_LSB +: 2]}
      - {6'h00, delCode[0]};
    // Minimum cycle: status cycle plus one command clock plus waits
    minEnd = NDT_TSM_H + NDT_ONE_CLK_H
      + ((({5'h00, s.timing[NDT_WS_LSB +: 2]} + extraWs) << 1) & 7'h7F);
    readyAt = (rasEnd > minEnd) ? rasEnd : minEnd;
  end

  // Bus decode; unmapped words read zero and still acknowledge
  assign regHit = (wbAdr[NDT_ADDR_W-1:2] == NDT_TIMING_IDX);
  assign statHit = (wbAdr[NDT_ADDR_W-1:2] == NDT_STATUS_IDX);
  // Half period tick drives both processor clock phases
  assign tick = (s.divCnt == 16'(HALF_CYCLES - 1));

  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.ready = 1'b0;
    // Single-wait Wishbone slave: ack the cycle after strobe, then drop it
    next_s.ack = wbCyc && wbStb && !s.ack;
    if (wbCyc && wbStb && !s.ack) begin
      if (wbWe && regHit) begin
        // Reserved bits never stored
        if (wbSel[0]) begin
          next_s.timing[7:0] = wbDatIn[7:0] & NDT_KEEP_MASK[7:0];
        end
        if (wbSel[1]) begin
          next_s.timing[15:8] = wbDatIn[15:8] & NDT_KEEP_MASK[15:8];
        end
      end
      if (regHit) begin
        next_s.rdData = {16'h0000, s.timing & NDT_KEEP_MASK};
      end else if (statHit) begin
        next_s.rdData = {24'h000000, s.state == NDT_RUN, s.lastWrite, s.isWrite,
          s.rasN, s.casN, s.colSel, s.pOe, s.ready};
      end else begin
        next_s.rdData = 32'h00000000;
      end
    end
    // Processor clock divider
    next_s.divCnt = tick ? 16'h0000 : s.divCnt + 16'h0001;
    if (tick) begin
      next_s.pclk = !s.pclk;
    end
    // Read data stays driven until the processor takes it
    if (s.pOe && dataLatched) begin
      next_s.pOe = 1'b0;
    end
    case (s.state)
      NDT_IDLE: begin
        // A status strobe on a half tick opens a cycle
        if (tick && (!statusStrobeA_n || !statusStrobeB_n)) begin
          next_s.state = NDT_RUN;
          next_s.half = 7'h01;
          next_s.isWrite = !statusStrobeA_n;
          next_s.rawHit = statusStrobeA_n && s.lastWrite && !s.timing[NDT_RAW_DIS_BIT];
          next_s.emsHit = expansionAccess;
          next_s.ilvHit = interleaveMiss;
          next_s.sameBank = interleaveOn && s.lastValid && (bankSel == s.lastBank);
          next_s.lastBank = bankSel;
          next_s.lastValid = 1'b1;
        end
      end
      NDT_RUN: begin
        // Each half tick advances the half count; any strobe edges due at that count move together
        if (tick) begin
          next_s.half = s.half + 7'h01;
          if (s.half == rasStart) begin
            next_s.rasN = 1'b0;
          end
          if (s.half == rasStart + NDT_ONE_CLK_H) begin
            next_s.colSel = 1'b1;
          end
          if (s.half == casStart) begin
            next_s.casN = 1'b0;
            next_s.wrN = !s.isWrite;
          end
          if (s.half == casEnd) begin
            next_s.casN = 1'b1;
            next_s.wrN = 1'b1;
            if (!s.isWrite) begin
              next_s.pData = dramDataIn;
              next_s.pOe = 1'b1;
            end
          end
          if (s.half == rasEnd) begin
            next_s.rasN = 1'b1;
            next_s.colSel = 1'b0;
          end
          if (s.half >= readyAt) begin
            next_s.ready = 1'b1;
            next_s.state = NDT_IDLE;
            next_s.lastWrite = s.isWrite;
            next_s.rasN = 1'b1;
            next_s.casN = 1'b1;
            next_s.wrN = 1'b1;
            next_s.colSel = 1'b0;
          end
        end
      end
      default: begin
        next_s.state = NDT_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.timing <= NDT_TIMING_RESET;
      s.state <= NDT_IDLE;
      s.rasN <= 1'b1;
      s.casN <= 1'b1;
      s.wrN <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops
  assign wbDatOut = s.rdData;
  assign wbAck = s.ack;
  assign procClock = s.pclk;
  assign rowStrobe_n = s.rasN;
  assign colStrobe_n = s.casN;
  assign colAddrSel = s.colSel;
  assign dramWrite_n = s.wrN;
  assign readyOut = s.ready;
  assign procDataOut = s.pData;
  assign procDataOe = s.pOe;
  // Cache stays off: non-page mode has no external cache path
  assign extCacheEnable = 1'b0;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Reserved bits read back zero
  reserved_zero_a: assert property (wbAck && regHit |-> wbDatOut[15] == 1'b0 && wbDatOut[7] == 1'b0)
    else $error("reserved timing bits read nonzero");
  // Register write visible on the next cycle
  write_now_a: assert property (wbCyc && wbStb && !wbAck && wbWe && regHit && wbSel[1]
    |=> s.timing[14:8] == $past(wbDatIn[14:8]))
    else $error("timing write not applied at once");
  // Row address present when row strobe falls
  row_first_a: assert property ($fell(rowStrobe_n) |-> !colAddrSel)
    else $error("column address before row strobe");
  // Column address switch exactly one processor clock after row strobe
  row_hold_a: assert property ($fell(rowStrobe_n) |-> !colAddrSel ##1 !colAddrSel ##1 (HALF_CYCLES != 1 || colAddrSel))
    else $error("row address hold too short");
  // Column strobe only while row strobe active
  col_in_row_a: assert property (!colStrobe_n |-> !rowStrobe_n)
    else $error("column strobe outside row strobe");
  // Read data stays until latched
  data_hold_a: assert property (procDataOe && !dataLatched |=> procDataOe)
    else $error("read data dropped before latch");
  // Ready is a single pulse returning to idle
  ready_pulse_a: assert property (readyOut |-> s.state == NDT_IDLE ##1 !readyOut)
    else $error("ready not a single pulse");
  // Cache never enabled
  no_cache_a: assert property (!extCacheEnable)
    else $error("external cache enabled");
  // Delayed row start never before Tsm+1 on read after write
  raw_delay_a: assert property (s.rawHit && s.state == NDT_RUN |-> rasStart >= NDT_TSM_H + NDT_RAW_OFF_H)
    else $error("read after write row start early");

  read_cycle_c: cover property (s.state == NDT_RUN && !s.isWrite ##[1:200] readyOut);
  write_cycle_c: cover property (!dramWrite_n ##[1:200] readyOut);
  raw_cycle_c: cover property (s.rawHit && readyOut);
  bus_write_c: cover property (wbAck && wbWe && regHit);

endmodule : ndt_timing_gen
`default_nettype wire

// [bench/ndt_dram_model.sv]
// Far-side model: DRAM data source and processor read latch
`timescale 1ns/100ps
`default_nettype none
module ndt_dram_model
  import ndt_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic colStrobe_n, // Column strobe from design
  input wire logic dramWrite_n, // Write enable from design
  input wire logic procDataOe, // Design drives read data
  output logic [15:0] dramDataIn, // Data toward design
  output var logic dataLatched, // Processor took the data
  output var logic [15:0] word // Word of the current read
);
  logic colSeen; // Column strobe one clock ago
  logic [15:0] idlePat; // Changing pattern on a released bus
  logic [1:0] latchCnt; // Slow latch delay
  initial begin
    word = 16'h5A3C;
    idlePat = 16'hC33C;
    colSeen = 1'b1;
    dataLatched = 1'b0;
    latchCnt = 2'h0;
  end
  // Outputs drive only during a read column; otherwise the bus shows a moving pattern
  assign dramDataIn = (!colStrobe_n && dramWrite_n) ? word : idlePat;
  // New word after each column strobe, read or write; the processor latches a few clocks late, never early
  always @(posedge clk) begin
    colSeen <= colStrobe_n;
    idlePat <= ~idlePat;
    if (colStrobe_n && !colSeen) word <= word + 16'h1357;
    if (dataLatched) begin
      dataLatched <= 1'b0;
      latchCnt <= 2'h0;
    end else if (procDataOe) begin
      latchCnt <= latchCnt + 2'h1;
      dataLatched <= (latchCnt == 2'h2);
    end
  end
endmodule : ndt_dram_model
`default_nettype wire

// [bench/ndt_timing_gen_tb.sv]
// Self-checking bench for the non-page DRAM timing generator
`timescale 1ns/100ps
`default_nettype none
module ndt_timing_gen_tb
  import ndt_pkg::*;
;
  logic clk, reset, wbCyc, wbStb, wbWe, wbAck, stA_n, stB_n, ilvOn, ilvMiss, expAcc, dataLatched;
  logic procClock, rowStrobe_n, colStrobe_n, colAddrSel, dramWrite_n, readyOut, procDataOe, extCacheEnable;
  logic [1:0] bankSel; // Bank of the access
  logic [NDT_ADDR_W-1:0] wbAdr; // Byte address
  logic [3:0] wbSel; // Byte selects
  logic [31:0] wbDatIn, wbDatOut, rdVal; // Bus data and last read
  logic [15:0] dramDataIn, procDataOut, memWord, cfg, lfsr; // Data, expected timing word, random state
  int nMismatch, cmpCount, lastWr, lastBank, i;
  localparam logic [NDT_ADDR_W-1:0] TIM_ADR = NDT_ADDR_W'({NDT_TIMING_IDX, 2'h0}); // Timing register
  // One system clock per half period keeps half steps countable edge by edge
  ndt_timing_gen #(.HALF_CYCLES(1)) u_dut (.clk(clk), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .statusStrobeA_n(stA_n), .statusStrobeB_n(stB_n), .bankSel(bankSel), .interleaveOn(ilvOn),
    .interleaveMiss(ilvMiss), .expansionAccess(expAcc), .dataLatched(dataLatched),
    .dramDataIn(dramDataIn), .procClock(procClock), .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n),
    .colAddrSel(colAddrSel), .dramWrite_n(dramWrite_n), .readyOut(readyOut), .procDataOut(procDataOut),
    .procDataOe(procDataOe), .extCacheEnable(extCacheEnable));
  ndt_dram_model u_mem (.clk(clk), .colStrobe_n(colStrobe_n), .dramWrite_n(dramWrite_n),
    .procDataOe(procDataOe), .dramDataIn(dramDataIn), .dataLatched(dataLatched), .word(memWord));
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Verdict and end of run
  task automatic stopTest();
    $display("counts: %0d compared, %0d mismatched", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stopTest
  // Value comparison
  task automatic chkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chkVal
  // Edge position comparison, in half clocks
  task automatic chkTime(input string what, input int exp, input int got);
    cmpCount++;
    if (got != exp) begin
      nMismatch++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask : chkTime
  // Galois-free shift register for repeatable stimulus
  function automatic logic [15:0] nextRand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nextRand
  // Classic Wishbone single cycle; the request stands until ack is sampled
  task automatic wbXfer(input logic we, input logic [NDT_ADDR_W-1:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatIn <= dat;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1);
    rdVal = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    // Counted from the launch edge: taken one edge later, ack sampled the edge after
    chkTime("ack latency", 2, n);
    @(posedge clk);
  endtask : wbXfer
  // Program timing; status-started mode keeps the read-after-write penalty off
  task automatic setCfg(input logic [15:0] v);
    if (v[NDT_MODE_LSB +: 2] == NDT_MODE_FROM_STATUS) v[NDT_RAW_DIS_BIT] = 1'b1;
    cfg = v;
    wbXfer(1'b1, TIM_ADR, {16'h0, v});
  endtask : setCfg
  // One DRAM cycle; edge positions are counted in half clocks from the status sample
  task automatic dramCycle(input logic wr, input logic il, input logic ms, input logic ex, input logic [1:0] bk);
    int h, tRas, tSel, tCas, tCasE, tRasE, tOe, raw, off, ras, del, cas, casE, rasE, xtra, rdy;
    logic [15:0] expD, gotD;
    logic pcLast, pcBad, wrN; // Last clock level, toggle fault, write enable at column start
    raw = !wr && lastWr && !cfg[NDT_RAW_DIS_BIT];
    off = (raw && ms) ? 8 : (ms || ex) ? 4 : raw ? 2 : 0;
    ras = off ? 2 + off : (il && bk == lastBank) ? 3 : (cfg[NDT_MODE_LSB +: 2] == NDT_MODE_FROM_STATUS) ? 1 : 2;
    del = wr ? cfg[NDT_WR_DEL_LSB +: 2] : cfg[NDT_RD_DEL_LSB +: 2];
    cas = ras + 2 + del;
    casE = cas + 2 + cfg[NDT_CASW_LSB +: 3] - (del == 1 || del == 2);
    rasE = casE + 2 + cfg[NDT_HOLD_LSB +: 2] - del % 2;
    xtra = wr ? (ms || ex) : (raw && ms) ? 3 : (ms || ex) ? 2 : raw;
    rdy = 4 + 2 * (cfg[NDT_WS_LSB +: 2] + xtra);
    if (rasE > rdy) rdy = rasE;
    @(posedge clk);
    stA_n <= !wr;
    stB_n <= wr;
    ilvOn <= il;
    ilvMiss <= ms;
    expAcc <= ex;
    bankSel <= bk;
    @(posedge clk);
    stA_n <= 1'b1;
    stB_n <= 1'b1;
    tRas = -1;
    tSel = -1;
    tCas = -1;
    tCasE = -1;
    tRasE = -1;
    tOe = -1;
    pcBad = 1'b0;
    pcLast = 1'b0;
    wrN = 1'b1;
    for (h = 1; h < 60 && readyOut !== 1'b1; h++) begin
      @(posedge clk);
      #1;
      // One system clock per half period: the processor clock flips on every edge
      if (h > 1 && procClock === pcLast) pcBad = 1'b1;
      pcLast = procClock;
      if (tRas < 0 && rowStrobe_n === 1'b0) tRas = h;
      if (tRas >= 0 && tRasE < 0 && rowStrobe_n === 1'b1) tRasE = h;
      if (tSel < 0 && colAddrSel === 1'b1) tSel = h;
      if (tCas >= 0 && tCasE < 0 && colStrobe_n === 1'b1) tCasE = h;
      if (tCas < 0 && colStrobe_n === 1'b0) begin
        tCas = h;
        expD = memWord;
        wrN = dramWrite_n;
      end
      if (tOe < 0 && procDataOe === 1'b1) begin
        tOe = h;
        gotD = procDataOut;
      end
    end
    chkTime("row start", ras, tRas);
    chkTime("column select", ras + 2, tSel);
    chkTime("column start", cas, tCas);
    chkTime("column end", casE, tCasE);
    chkTime("row end", rasE, tRasE);
    chkTime("ready", rdy, h - 1);
    if (!wr) chkVal("read data", {16'h0, expD}, {16'h0, gotD});
    chkVal("cache enable", 32'h0, {31'h0, extCacheEnable});
    chkVal("write enable", {31'h0, !wr}, {31'h0, wrN});
    chkVal("processor clock toggle", 32'h0, {31'h0, pcBad});
    lastWr = wr;
    lastBank = bk;
  endtask : dramCycle
  // Main sequence
  initial begin
    {reset, stA_n, stB_n} = 3'h7;
    {wbCyc, wbStb, wbWe, ilvOn, ilvMiss, expAcc} = 6'h0;
    {wbAdr, wbSel, wbDatIn, bankSel} = '0;
    {nMismatch, cmpCount, lastWr, lastBank} = {32'h0, 32'h0, 32'h0, -32'sh1};
    lfsr = 16'h0022;
    cfg = 16'h0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    wbXfer(1'b0, TIM_ADR, 32'h0);
    chkVal("timing after reset", {16'h0, NDT_TIMING_RESET}, rdVal);
    wbXfer(1'b1, TIM_ADR, 32'hFFFF_FFFF);
    wbXfer(1'b0, TIM_ADR, 32'h0);
    chkVal("timing readback", 32'h0000_7F7F, rdVal);
    wbXfer(1'b1, 18'h00010, 32'h1234_5678);
    wbXfer(1'b0, 18'h00010, 32'h0);
    chkVal("unmapped read", 32'h0, rdVal);
    // Idle sequencer: only the two strobe bits read high
    wbXfer(1'b0, NDT_ADDR_W'({NDT_STATUS_IDX, 2'h0}), 32'h0);
    chkVal("status idle", 32'h0000_0018, rdVal);
    $display("test registers done");
    setCfg(16'h0000);
    dramCycle(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    dramCycle(1'b1, 1'b1, 1'b0, 1'b1, 2'h1);
    dramCycle(1'b1, 1'b1, 1'b0, 1'b0, 2'h1);
    dramCycle(1'b0, 1'b0, 1'b1, 1'b0, 2'h2);
    setCfg(16'hFFFF);
    dramCycle(1'b0, 1'b0, 1'b0, 1'b0, 2'h3);
    dramCycle(1'b1, 1'b0, 1'b0, 1'b0, 2'h3);
    $display("test corner cycles done");
    // Random timing words and access classes; status-started mode runs plain cycles only
    for (i = 0; i < 48; i++) begin
      lfsr = nextRand(lfsr);
      if (i % 4 == 0) setCfg(lfsr);
      lfsr = nextRand(lfsr);
      if (cfg[NDT_MODE_LSB +: 2] == NDT_MODE_FROM_STATUS) lfsr[3:1] = 3'h0;
      dramCycle(lfsr[0], lfsr[1], lfsr[2], lfsr[3], lfsr[5:4]);
    end
    $display("test random cycles done");
    stopTest();
  end
  // Watchdog against a hung handshake
  initial begin
    #300000;
    nMismatch++;
    stopTest();
  end
endmodule : ndt_timing_gen_tb
`default_nettype wire
